// [rtl/sdt_regs.svh]
`ifndef SDT_REGS_SVH
`define SDT_REGS_SVH

// Register indices; byte address is four times the index
`define SDT_IDX_COUNT_HIGH     8'hf0
`define SDT_IDX_COUNT_LOW      8'hf1
`define SDT_IDX_PRESCALE       8'hf2
`define SDT_IDX_CONTROL        8'hf3
`define SDT_BYTE_ADDR(idx)     ({2'h0, (idx), 2'h0})

// Reset values
`define SDT_RST_COUNT_HIGH     8'hff
`define SDT_RST_COUNT_LOW      8'hff
`define SDT_RST_PRESCALE       8'hff
`define SDT_RST_CONTROL        8'h14

// Control register bit positions
`define SDT_BIT_RUN            7
`define SDT_BIT_SINGLE         6
`define SDT_BIT_INMODE_A       5
`define SDT_BIT_INMODE_B       4
`define SDT_BIT_CLKSRC         3
`define SDT_BIT_INTSEL         2
`define SDT_BIT_OUTMODE_A      1
`define SDT_BIT_OUTMODE_B      0

// Clock source dividers
`define SDT_INT_DIV_LAST       2'h3
`define SDT_OSC_DIV            1024

`endif

// [rtl/sdt_pkg.sv]
`default_nettype none
package sdt_pkg;
    typedef logic [7:0] sdt_byte_t;
    typedef enum {SDT_OUT_OFF, SDT_OUT_SQUARE, SDT_OUT_PWM} sdt_out_mode_e;
endpackage
`default_nettype wire

// [rtl/sdt_prescaler.sv]
`include "sdt_regs.svh"
`default_nettype none
module sdt_prescaler
    import sdt_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      clear,
    input  wire logic      tick,
    input  wire sdt_byte_t divisor,
    output var  logic      dec_pulse
);
    sdt_byte_t cnt;
    logic      terminal;

    // Compared live, so a new divisor acts at once
    assign terminal = (cnt >= divisor);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else if (clear) begin
            cnt <= 8'h00;
        end else if (tick) begin
            if (terminal) begin
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_pulse <= 1'b0;
        end else begin
            dec_pulse <= tick & terminal & ~clear;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pulse_terminal_a: assert property (
        tick && !clear && cnt == divisor |=> dec_pulse && cnt == 8'h00)
        else $error("prescaler missed its terminal count");
endmodule // sdt_prescaler
`default_nettype wire

// [rtl/sdt_timer.sv]
// Decided for this implementation: the APB slave port.
`include "sdt_regs.svh"
`default_nettype none
module sdt_timer
    import sdt_pkg::*;
#(
    parameter int OSC_DIV = `SDT_OSC_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        osc_half_clk,
    input  wire logic        ext_int_pin,
    output var  logic        timer_output_pin,
    output var  logic        ext_int_channel
);
    localparam int              OSC_W    = $clog2(OSC_DIV);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

    logic [15:0]      count;
    logic [15:0]      const_val;
    sdt_byte_t        prescale_value;
    sdt_byte_t        timer_control;
    logic             new_const;
    logic [1:0]       int_div;
    logic             int_tick;
    logic [OSC_W-1:0] osc_div;
    logic             osc_tick;
    logic             osc_sync1;
    logic             osc_sync2;
    logic             osc_last;
    logic             ext_sync1;
    logic             ext_sync2;
    logic             dec_pulse;
    logic             tick;
    logic             running;
    logic             eoc;
    logic             setup;
    logic             access_wr;
    logic             hit;
    sdt_byte_t        rd_mux;
    logic             wr_high;
    logic             wr_low;
    logic             wr_presc;
    logic             wr_ctrl;
    logic             start_req;
    sdt_out_mode_e    out_mode;

    assign running = timer_control[`SDT_BIT_RUN];
    assign setup     = psel & ~penable;
    assign access_wr = psel & penable & pready & pwrite;

    // Address decode and read mux
    always_comb begin
        hit    = 1'b1;
        rd_mux = 8'h00;
        if (paddr == `SDT_BYTE_ADDR(`SDT_IDX_COUNT_HIGH)) begin
            rd_mux = count[15:8];
        end else if (paddr == `SDT_BYTE_ADDR(`SDT_IDX_COUNT_LOW)) begin
            rd_mux = count[7:0];
        end else if (paddr == `SDT_BYTE_ADDR(`SDT_IDX_PRESCALE)) begin
            rd_mux = prescale_value;
        end else if (paddr == `SDT_BYTE_ADDR(`SDT_IDX_CONTROL)) begin
            rd_mux = timer_control;
        end else begin
            hit = 1'b0;
        end
    end

    assign wr_high  = access_wr && paddr == `SDT_BYTE_ADDR(`SDT_IDX_COUNT_HIGH);
    assign wr_low   = access_wr && paddr == `SDT_BYTE_ADDR(`SDT_IDX_COUNT_LOW);
    assign wr_presc = access_wr && paddr == `SDT_BYTE_ADDR(`SDT_IDX_PRESCALE);
    assign wr_ctrl  = access_wr && paddr == `SDT_BYTE_ADDR(`SDT_IDX_CONTROL);

    // A stopped timer being started by this very write
    assign start_req = wr_ctrl & pwdata[`SDT_BIT_RUN] & ~running;

    // No wait state, yet every bus output leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Internal clock divided by four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_div  <= 2'h0;
            int_tick <= 1'b0;
        end else begin
            int_div  <= int_div + 2'h1;
            int_tick <= (int_div == `SDT_INT_DIV_LAST);
        end
    end

    // Oscillator clock is asynchronous: synchronise before edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync1 <= 1'b0;
            osc_sync2 <= 1'b0;
            osc_last  <= 1'b0;
        end else begin
            osc_sync1 <= osc_half_clk;
            osc_sync2 <= osc_sync1;
            osc_last  <= osc_sync2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_div  <= '0;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= 1'b0;
            if (osc_sync2 && !osc_last) begin
                if (osc_div == OSC_LAST) begin
                    osc_div  <= '0;
                    osc_tick <= 1'b1;
                end else begin
                    osc_div <= osc_div + OSC_W'(1);
                end
            end
        end
    end

    // Input-mode bits only matter to software when the oscillator is chosen
    assign tick = running & (timer_control[`SDT_BIT_CLKSRC] ? osc_tick : int_tick);

    sdt_prescaler u_prescaler (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (~running),
        .tick      (tick),
        .divisor   (prescale_value),
        .dec_pulse (dec_pulse)
    );

    // Underflow from zero; constant N gives N+1 decrements
    assign eoc = running & dec_pulse & (count == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {`SDT_RST_COUNT_HIGH, `SDT_RST_COUNT_LOW};
        end else if (eoc) begin
            count <= const_val;
        end else if (start_req && new_const) begin
            count <= const_val;
        end else if (running && dec_pulse) begin
            count <= count - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            const_val <= {`SDT_RST_COUNT_HIGH, `SDT_RST_COUNT_LOW};
        end else if (wr_high) begin
            const_val[15:8] <= pwdata[7:0];
        end else if (wr_low) begin
            const_val[7:0] <= pwdata[7:0];
        end
    end

    // Only constants written while stopped force a load at restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_const <= 1'b0;
        end else if ((wr_high || wr_low) && !running) begin
            new_const <= 1'b1;
        end else if (start_req) begin
            new_const <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_value <= `SDT_RST_PRESCALE;
        end else if (wr_presc) begin
            prescale_value <= pwdata[7:0];
        end
    end

    // A software write in the end-of-count cycle takes precedence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= `SDT_RST_CONTROL;
        end else if (wr_ctrl) begin
            timer_control <= pwdata[7:0];
        end else if (eoc && timer_control[`SDT_BIT_SINGLE]) begin
            timer_control[`SDT_BIT_RUN] <= 1'b0;
        end
    end

    always_comb begin
        if (timer_control[`SDT_BIT_OUTMODE_A]) begin
            out_mode = SDT_OUT_PWM;
        end else if (timer_control[`SDT_BIT_OUTMODE_B]) begin
            out_mode = SDT_OUT_SQUARE;
        end else begin
            out_mode = SDT_OUT_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_output_pin <= 1'b1;
        end else begin
            case (out_mode)
                SDT_OUT_OFF: begin
                    timer_output_pin <= 1'b1;
                end
                SDT_OUT_SQUARE: begin
                    if (eoc) begin
                        timer_output_pin <= ~timer_output_pin;
                    end
                end
                default: begin
                    if (eoc) begin
                        timer_output_pin <= timer_control[`SDT_BIT_OUTMODE_B];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
        end else begin
            ext_sync1 <= ext_int_pin;
            ext_sync2 <= ext_sync1;
        end
    end

    // Switching the source can make an edge; software guards that
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_int_channel <= 1'b0;
        end else if (timer_control[`SDT_BIT_INTSEL]) begin
            ext_int_channel <= ext_sync2;
        end else begin
            ext_int_channel <= eoc;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start_with_const;
        start_req && new_const;
    endsequence

    sequence s_int_period;
        !int_tick [*3] ##1 int_tick;
    endsequence

    sequence s_low_read;
        setup && !pwrite && paddr == `SDT_BYTE_ADDR(`SDT_IDX_COUNT_LOW);
    endsequence

    eoc_reload_a: assert property (
        eoc |=> count == $past(const_val))
        else $error("count not reloaded at end of count");

    count_step_a: assert property (
        running && dec_pulse && count != 16'h0000 |=> count == $past(count) - 16'h0001)
        else $error("count did not decrement by one");

    start_load_a: assert property (
        s_start_with_const |=> running && count == $past(const_val))
        else $error("stored constant not loaded at restart");

    stop_hold_a: assert property (
        !running && !start_req |=> $stable(count))
        else $error("count moved while stopped");

    run_const_a: assert property (
        running && (wr_high || wr_low) && !dec_pulse |=> $stable(count))
        else $error("running constant write touched count");

    single_stop_a: assert property (
        eoc && timer_control[`SDT_BIT_SINGLE] && !wr_ctrl |=> !running)
        else $error("single mode did not stop");

    cont_run_a: assert property (
        eoc && !timer_control[`SDT_BIT_SINGLE] && !wr_ctrl |=> running)
        else $error("continuous mode stopped");

    ctrl_write_a: assert property (
        wr_ctrl |=> timer_control == $past(pwdata[7:0]))
        else $error("control write lost");

    int_div_a: assert property (
        int_tick |=> s_int_period)
        else $error("internal tick not every fourth cycle");

    out_idle_a: assert property (
        out_mode == SDT_OUT_OFF |=> timer_output_pin)
        else $error("idle output not high");

    square_a: assert property (
        eoc && out_mode == SDT_OUT_SQUARE |=> timer_output_pin != $past(timer_output_pin))
        else $error("square output did not toggle");

    pwm_a: assert property (
        eoc && out_mode == SDT_OUT_PWM
        |=> timer_output_pin == $past(timer_control[`SDT_BIT_OUTMODE_B]))
        else $error("pwm output not copied");

    timer_irq_a: assert property (
        eoc && !timer_control[`SDT_BIT_INTSEL] |=> ext_int_channel)
        else $error("end of count raised no request");

    live_read_a: assert property (
        s_low_read |=> prdata[7:0] == $past(count[7:0]) && pready)
        else $error("low byte read not live");

    presc_read_a: assert property (
        setup && !pwrite && paddr == `SDT_BYTE_ADDR(`SDT_IDX_PRESCALE)
        |=> prdata == {24'h00_0000, $past(prescale_value)})
        else $error("prescale read not programmed value");
endmodule // sdt_timer
`default_nettype wire

// [bench/sdt_timer_test.sv]
`include "sdt_regs.svh"
`default_nettype none
module sdt_timer_test
    import sdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [11:0] A_CH = `SDT_BYTE_ADDR(`SDT_IDX_COUNT_HIGH);
    localparam logic [11:0] A_CL = `SDT_BYTE_ADDR(`SDT_IDX_COUNT_LOW);
    localparam logic [11:0] A_PS = `SDT_BYTE_ADDR(`SDT_IDX_PRESCALE);
    localparam logic [11:0] A_CT = `SDT_BYTE_ADDR(`SDT_IDX_CONTROL);
    localparam int          TMAX = 20000;
    localparam logic [11:0] RA[5] = '{A_CH, A_CL, A_PS, A_CT, 12'h3d0};
    localparam sdt_byte_t   RV[5] = '{8'hff, 8'hff, 8'hff, 8'h14, 8'h00};

    typedef struct {sdt_byte_t p; sdt_byte_t lo; int per;} sdt_row_s;
    // Period in pclk = (constant + 1) * (prescale + 1) * 4
    sdt_row_s rows[5] = '{'{8'h00, 8'h03, 16}, '{8'h01, 8'h03, 32}, '{8'h00, 8'h00, 4},
                          '{8'h02, 8'h01, 24}, '{8'h03, 8'h00, 16}};

    logic        pclk         = 1'b0;
    logic        presetn      = 1'b0;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [11:0] paddr        = 12'h000;
    logic [31:0] pwdata       = 32'h0;
    logic        osc_half_clk = 1'b0;
    logic        ext_int_pin  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_output_pin;
    logic        ext_int_channel;
    int          mismatches   = 0;
    int          total_checks = 0;
    int          cyc          = 0;
    int          n;
    int          k;
    sdt_byte_t   rd;
    sdt_byte_t   v1;
    logic        err;
    logic        p1;

    sdt_timer #(.OSC_DIV(4)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_half_clk(osc_half_clk), .ext_int_pin(ext_int_pin),
        .timer_output_pin(timer_output_pin), .ext_int_channel(ext_int_channel)
    );

    always #5 pclk = ~pclk;
    // Half period of 17.3 keeps all but every fiftieth oscillator edge off the pclk edges
    always #17.3 osc_half_clk = ~osc_half_clk;

    always @(posedge pclk) begin
        cyc++;
        if (cyc == TMAX) begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input sdt_byte_t d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Ends on pready; only the cycle ceiling ends a wait that never sees it
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask

    // Counts edges up to and including the one that sees the pulse
    task automatic eoc(output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (ext_int_channel !== 1'b1 && c < 3000);
        if (ext_int_channel !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: no end of count seen", $time);
        end
    endtask

    task automatic pulses(input int c, output int cnt);
        cnt = 0;
        repeat (c) begin
            @(posedge pclk);
            if (ext_int_channel === 1'b1) cnt++;
        end
    endtask

    task automatic start(input sdt_byte_t p, input sdt_byte_t lo, input sdt_byte_t ctl);
        apb(1'b1, A_PS, p);
        apb(1'b1, A_CH, 8'h00);
        apb(1'b1, A_CL, lo);
        apb(1'b1, A_CT, ctl);
    endtask

    task automatic reset_vals;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, RA[i], 8'h00);
            check(rd, RV[i]);
            check(err, i == 4);
        end
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check(timer_output_pin, 1'b1);
        reset_vals();
        foreach (rows[i]) begin
            start(rows[i].p, rows[i].lo, 8'h81);
            eoc(n);
            idle(1);
            p1 = timer_output_pin;
            eoc(n);
            idle(1);
            check(n + 1, rows[i].per);
            check(timer_output_pin, !p1);
            apb(1'b1, A_CT, 8'h00);
        end
        start(8'h00, 8'h03, 8'h81);
        eoc(n);
        apb(1'b1, A_CL, 8'h07);
        eoc(n);
        check(n <= 17, 1'b1);
        idle(1);
        eoc(n);
        check(n + 1, 32);
        // Halving the rate mid-period must show in this very period
        apb(1'b1, A_PS, 8'h01);
        eoc(n);
        check(n > 40 && n < 64, 1'b1);
        apb(1'b1, A_CT, 8'h00);
        start(8'h00, 8'hff, 8'h80);
        apb(1'b0, A_CL, 8'h00);
        v1 = rd;
        idle(4);
        apb(1'b0, A_CL, 8'h00);
        check(rd !== v1, 1'b1);
        apb(1'b1, A_CT, 8'h00);
        apb(1'b0, A_CL, 8'h00);
        v1 = rd;
        idle(20);
        apb(1'b0, A_CL, 8'h00);
        check(rd, v1);
        apb(1'b1, A_CT, 8'h80);
        apb(1'b0, A_CL, 8'h00);
        check(v1 - rd <= 2, 1'b1);
        apb(1'b1, A_CT, 8'h00);
        apb(1'b1, A_CL, 8'h10);
        apb(1'b1, A_CT, 8'h80);
        apb(1'b0, A_CL, 8'h00);
        check(8'h10 - rd <= 2, 1'b1);
        apb(1'b1, A_CT, 8'h00);
        apb(1'b1, A_CL, 8'h03);
        apb(1'b1, A_CT, 8'hc1);
        eoc(n);
        idle(2);
        apb(1'b0, A_CT, 8'h00);
        check(rd, 8'h41);
        apb(1'b0, A_CL, 8'h00);
        check(rd, 8'h03);
        pulses(40, k);
        check(k, 0);
        apb(1'b1, A_CT, 8'h00);
        idle(2);
        check(timer_output_pin, 1'b1);
        apb(1'b1, A_CT, 8'h82);
        eoc(n);
        idle(1);
        check(timer_output_pin, 1'b0);
        apb(1'b1, A_CT, 8'h83);
        eoc(n);
        idle(1);
        check(timer_output_pin, 1'b1);
        // Select flipped while stopped so a stray edge cannot matter
        apb(1'b1, A_CT, 8'h00);
        apb(1'b1, A_CT, 8'h84);
        pulses(20, k);
        check(k, 0);
        check(timer_output_pin, 1'b1);
        ext_int_pin <= 1'b1;
        idle(6);
        check(ext_int_channel, 1'b1);
        ext_int_pin <= 1'b0;
        apb(1'b1, A_CT, 8'h00);
        apb(1'b1, A_CL, 8'h01);
        apb(1'b1, A_CT, 8'h89);
        eoc(n);
        idle(1);
        eoc(n);
        check(n + 1 >= 26 && n + 1 <= 30, 1'b1);
        presetn <= 1'b0;
        idle(2);
        check(timer_output_pin, 1'b1);
        check(ext_int_channel, 1'b0);
        presetn <= 1'b1;
        reset_vals();
        final_report();
    end
endmodule // sdt_timer_test
`default_nettype wire
